/* bench/eag_regfile_model.sv */
// Register file model that feeds base and index contents
`timescale 1ns/1ps
module eag_regfile_model (
   input  wire logic        clk_i,
   input  wire logic        wr_i,
   input  wire logic [4:0]  wr_num_i,
   input  wire logic [31:0] wr_val_i,
   input  wire logic [4:0]  base_reg_i,
   input  wire logic [4:0]  index_reg_i,
   output logic      [31:0] base_val_o,
   output logic      [31:0] index_val_o
);
   logic [31:0] regs_q [32];
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         regs_q[wr_num_i] <= wr_val_i;
      end
   end
   // Reads are combinational, as from a register file port
   assign base_val_o  = regs_q[base_reg_i];
   assign index_val_o = regs_q[index_reg_i];
endmodule // eag_regfile_model

/* bench/effective_address_generator_tb.sv */
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module effective_address_generator_tb;
   localparam eag_pkg::eag_op_e NRM = eag_pkg::EAG_NORMAL;
   localparam eag_pkg::eag_op_e CLR = eag_pkg::EAG_CALL_RELATIVE;
   localparam eag_pkg::eag_op_e DJN = eag_pkg::EAG_DECREMENT_BRANCH_NONZERO;
   localparam logic [4:0]       NI  = 5'h1F;
   localparam logic [31:0]      NEG_ONE = 32'hFFFFFFFF;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 req = 1'b0;
   eag_pkg::eag_repr_e   repr = eag_pkg::EAG_LINEAR;
   eag_pkg::eag_opmode_e opmode = eag_pkg::EAG_CALC_MODE;
   eag_pkg::eag_op_e     opclass = NRM;
   eag_pkg::eag_base_e   base_src = eag_pkg::EAG_BASE_REG;
   eag_pkg::eag_dlen_e   dlen = eag_pkg::EAG_DLEN_8;
   eag_pkg::eag_rsize_e  rsize = eag_pkg::EAG_QUAD;
   logic                 io_op = 1'b0;
   logic                 mmu_en = 1'b1;
   logic                 use_idx = 1'b0;
   logic                 idx_long = 1'b0;
   logic                 use_disp = 1'b0;
   logic                 wr_en = 1'b0;
   logic [4:0]           wr_num = 5'h00;
   logic [4:0]           base_reg = 5'h01;
   logic [4:0]           idx_reg = 5'h02;
   logic [31:0]          wr_val = 32'h0;
   logic [31:0]          pc = 32'h00ABCDEF;
   logic [31:0]          instr_addr = 32'h12345678;
   logic [31:0]          disp = 32'h0;
   logic [31:0]          base_val;
   logic [31:0]          idx_val;
   logic [31:0]          ea;
   logic                 valid;
   logic                 translate;
   logic                 fault;
   logic                 reg_op;
   logic [4:0]           reg_num;
   eag_pkg::eag_space_e  space;
   eag_pkg::eag_rsize_e  reg_size;
   int                   mismatches = 0;
   int                   num_checks = 0;
   int                   cycles = 0;

   eag_top i_eag_top (.ref_clk_i(clk), .rst_n_i(rst_n), .req_i(req),
      .repr_i(repr), .opmode_i(opmode), .opclass_i(opclass),
      .base_src_i(base_src), .io_op_i(io_op), .mmu_en_i(mmu_en),
      .base_reg_i(base_reg), .base_val_i(base_val), .pc_i(pc),
      .instr_addr_i(instr_addr), .use_index_i(use_idx),
      .index_reg_i(idx_reg), .index_long_i(idx_long),
      .index_val_i(idx_val), .use_disp_i(use_disp), .disp_i(disp),
      .disp_len_i(dlen), .reg_size_i(rsize), .valid_o(valid), .ea_o(ea),
      .space_o(space), .translate_o(translate), .fault_o(fault),
      .reg_op_o(reg_op), .reg_num_o(reg_num), .reg_size_o(reg_size));

   eag_regfile_model i_eag_regfile_model (.clk_i(clk), .wr_i(wr_en),
      .wr_num_i(wr_num), .wr_val_i(wr_val), .base_reg_i(base_reg),
      .index_reg_i(idx_reg), .base_val_o(base_val), .index_val_o(idx_val));

   always #20 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One request cycle; the answer is judged in the cycle after capture
   task automatic issue();
      @(negedge clk);
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      cmp({31'h0, valid}, 32'h1);
   endtask

   task automatic wr(logic [4:0] n, logic [31:0] v);
      wr_num = n;
      wr_val = v;
      wr_en = 1'b1;
      @(negedge clk);
   endtask

   // Index NI means no index, dl bit 2 means no displacement
   task automatic calc(eag_pkg::eag_op_e c, logic [4:0] b, logic [4:0] ix,
                       logic [31:0] d, logic [2:0] dl, logic [31:0] e,
                       logic f);
      opmode = eag_pkg::EAG_CALC_MODE;
      base_src = eag_pkg::EAG_BASE_REG;
      opclass = c;
      base_reg = b;
      idx_reg = ix;
      use_idx = (ix != NI);
      idx_long = (ix != 5'h09);
      use_disp = !dl[2];
      dlen = eag_pkg::eag_dlen_e'(dl[1:0]);
      disp = d;
      issue();
      cmp(ea, e);
      cmp({31'h0, fault}, {31'h0, f});
      cmp({30'h0, space}, 32'h1);
   endtask

   task automatic op(logic [2:0] m, logic io, logic [31:0] e,
                     logic [1:0] sp, logic tr);
      opmode = eag_pkg::eag_opmode_e'(m);
      io_op = io;
      issue();
      cmp(ea, e);
      cmp({30'h0, space}, {30'h0, sp});
      cmp({31'h0, translate}, {31'h0, tr});
      cmp({31'h0, reg_op}, {31'h0, m == 3'h0});
   endtask

   task automatic t_compact();
      repr = eag_pkg::EAG_COMPACT;
      calc(NRM, 5'h01, 5'h02, 32'h0, 3'h4, 32'h00001110, 1'b0);
      calc(CLR, 5'h01, NI, 32'hFFF, 3'h1, 32'h1235, 1'b0);
      calc(DJN, 5'h01, NI, 32'hF0, 3'h0, 32'h1144, 1'b0);
      calc(NRM, 5'h01, NI, 32'hF0, 3'h0, 32'h1224, 1'b0);
      calc(CLR, 5'h01, NI, 32'hFEDC, 3'h2, 32'h1358, 1'b0);
      calc(NRM, 5'h01, 5'h02, 32'h5, 3'h0, 32'h00001110, 1'b1);
      $display("compact tests done");
   endtask

   task automatic t_segmented();
      repr = eag_pkg::EAG_SEGMENTED;
      calc(NRM, 5'h03, 5'h04, NEG_ONE, 3'h3, 32'h2110F, 1'b0);
      calc(NRM, 5'h05, 5'h06, 32'h2, 3'h0, 32'h8313577D, 1'b0);
      calc(CLR, 5'h03, NI, 32'h1, 3'h0, 32'h00025677, 1'b0);
      calc(NRM, 5'h05, NI, 32'h0, 3'h4, 32'h8313579B, 1'b0);
      $display("segmented tests done");
   endtask

   task automatic t_linear();
      repr = eag_pkg::EAG_LINEAR;
      calc(NRM, 5'h07, 5'h08, 32'h9B, 3'h0, 32'hFFFFFF, 1'b0);
      calc(NRM, 5'h07, 5'h09, 32'h0, 3'h4, 32'h00FFFFFE, 1'b0);
      calc(DJN, 5'h07, NI, 32'hF0, 3'h0, 32'hFFFF10, 1'b0);
      calc(NRM, 5'h06, NI, 32'h80, 3'h0, 32'hFFFFFF60, 1'b0);
      $display("linear tests done");
   endtask

   task automatic t_modes();
      use_idx = 1'b0;
      use_disp = 1'b0;
      base_reg = 5'h03;
      op(3'h1, 1'b0, 32'h00ABCDEF, 2'h2, 1'b1);
      op(3'h2, 1'b0, 32'h00025678, 2'h1, 1'b1);
      op(3'h2, 1'b1, 32'h00025678, 2'h3, 1'b1);
      base_src = eag_pkg::EAG_BASE_INSTR;
      op(3'h4, 1'b0, 32'h00005678, 2'h3, 1'b1);
      op(3'h0, 1'b0, 32'h0, 2'h0, 1'b0);
      cmp({27'h0, reg_num}, 32'h3);
      cmp({30'h0, reg_size}, 32'h3);
      mmu_en = 1'b0;
      base_src = eag_pkg::EAG_BASE_PC;
      repr = eag_pkg::EAG_COMPACT;
      op(3'h3, 1'b0, 32'h0000CDEF, 2'h2, 1'b0);
      op(3'h1, 1'b0, 32'h0000CDEF, 2'h2, 1'b0);
      op(3'h2, 1'b0, 32'h00005678, 2'h1, 1'b0);
      $display("mode tests done");
   endtask

   task automatic t_reg_zero();
      calc(NRM, 5'h00, NI, 32'h0, 3'h4, 32'h00000010, 1'b1);
      repr = eag_pkg::EAG_LINEAR;
      calc(NRM, 5'h07, 5'h00, 32'h0, 3'h4, 32'h01000010, 1'b1);
      base_reg = 5'h00;
      opmode = eag_pkg::EAG_INDIRECT_REGISTER_MODE;
      issue();
      cmp({31'h0, fault}, 32'h1);
      $display("register zero tests done");
   endtask

   initial begin
      wr(5'h00, 32'h00000010);
      wr(5'h01, 32'h00001234);
      wr(5'h02, 32'h0000FEDC);
      wr(5'h03, 32'h00025678);
      wr(5'h04, 32'h0000BA98);
      wr(5'h05, 32'h8313579B);
      wr(5'h06, 32'hFFFFFFE0);
      wr(5'h07, 32'h01000000);
      wr(5'h08, 32'h00000064);
      wr(5'h09, 32'h0000FFFE);
      wr(5'h1F, 32'h00000000);
      wr_en = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_compact();
      t_segmented();
      t_linear();
      t_modes();
      t_reg_zero();
      conclude();
   end
endmodule // effective_address_generator_tb

/* hdl/eag_defs.svh */
// Constants for the effective address generator
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH
`define EAG_AW       32
`define EAG_CW       16
`define EAG_RW       5
`define EAG_SEG_BIT  31
`define EAG_SS_OFF   16
`define EAG_LS_OFF   24
`define EAG_D8       8
`define EAG_D12      12
`define EAG_D16      16
`define EAG_ZERO32   32'h0000_0000
`define EAG_ZERO16   16'h0000
`define EAG_REG_ZERO 5'h00
`define EAG_LO16     32'h0000_FFFF
`define EAG_LO8      32'h0000_00FF
`endif

/* hdl/eag_pkg.sv */
// Types for the effective address generator
package eag_pkg;
   typedef enum logic [1:0] {
      EAG_COMPACT, EAG_SEGMENTED, EAG_LINEAR
   } eag_repr_e;
   typedef enum logic [2:0] {
      EAG_REGISTER_MODE, EAG_IMMEDIATE_MODE,
      EAG_INDIRECT_REGISTER_MODE, EAG_CALC_MODE, EAG_IO_MODE
   } eag_opmode_e;
   typedef enum logic [1:0] {
      EAG_NORMAL, EAG_CALL_RELATIVE, EAG_DECREMENT_BRANCH_NONZERO
   } eag_op_e;
   typedef enum logic [1:0] {
      EAG_BASE_REG, EAG_BASE_PC, EAG_BASE_INSTR
   } eag_base_e;
   typedef enum logic [1:0] {
      EAG_DLEN_8, EAG_DLEN_12, EAG_DLEN_16, EAG_DLEN_32
   } eag_dlen_e;
   typedef enum logic [1:0] {
      EAG_SPACE_NONE, EAG_SPACE_DATA, EAG_SPACE_INSTR, EAG_SPACE_IO
   } eag_space_e;
   typedef enum logic [1:0] {
      EAG_BYTE, EAG_WORD, EAG_LONG, EAG_QUAD
   } eag_rsize_e;
endpackage

/* hdl/eag_top.sv */
// Effective address generator, one registered stage
`timescale 1ns/1ps
`include "eag_defs.svh"
// Notes on behaviour
// - Short displacements sign-extend; decrement-branch zero-extends
// - Compact mode forbids index plus displacement
// - Call-relative and decrement-branch subtract displacement
// - Compact addresses wrap in 16 bits
// - Register zero never indirect, calculation base or index
// - Word index sign-extends to 32 bits
// - Bit 31 picks small or large segment
// - Segment size and number come from base
// - Offsets wrap in 16 or 24 bits
// - Base plus optional index plus optional displacement
// - Linear addresses wrap in 32 bits
// - Immediate operand read from instruction space
// - Indirect uses register; opcode picks data/IO
// - Register operand selected at opcode size
// - Translate logical addresses only when enabled
// - I/O port address used without arithmetic
// - Compact base from register, PC or instruction
module eag_top (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 req_i,
   input  eag_pkg::eag_repr_e        repr_i,
   input  eag_pkg::eag_opmode_e      opmode_i,
   input  eag_pkg::eag_op_e          opclass_i,
   input  eag_pkg::eag_base_e        base_src_i,
   input  wire logic                 io_op_i,
   input  wire logic                 mmu_en_i,
   input  wire logic [`EAG_RW-1:0]   base_reg_i,
   input  wire logic [`EAG_AW-1:0]   base_val_i,
   input  wire logic [`EAG_AW-1:0]   pc_i,
   input  wire logic [`EAG_AW-1:0]   instr_addr_i,
   input  wire logic                 use_index_i,
   input  wire logic [`EAG_RW-1:0]   index_reg_i,
   input  wire logic                 index_long_i,
   input  wire logic [`EAG_AW-1:0]   index_val_i,
   input  wire logic                 use_disp_i,
   input  wire logic [`EAG_AW-1:0]   disp_i,
   input  eag_pkg::eag_dlen_e        disp_len_i,
   input  eag_pkg::eag_rsize_e       reg_size_i,
   output logic                      valid_o,
   output logic [`EAG_AW-1:0]        ea_o,
   output eag_pkg::eag_space_e       space_o,
   output logic                      translate_o,
   output logic                      fault_o,
   output logic                      reg_op_o,
   output logic [`EAG_RW-1:0]        reg_num_o,
   output eag_pkg::eag_rsize_e       reg_size_o
);

   // ----------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------
   // Extension of short fields to full width
   // ----------------------------------------------------------
   function automatic logic [`EAG_AW-1:0] eag_ext(
      input logic [`EAG_AW-1:0] v,
      input eag_pkg::eag_dlen_e l,
      input logic               z);
      logic s8;
      logic s12;
      logic s16;
      s8  = ~z & v[`EAG_D8-1];
      s12 = ~z & v[`EAG_D12-1];
      s16 = ~z & v[`EAG_D16-1];
      case (l)
         eag_pkg::EAG_DLEN_8:
            eag_ext = {{(`EAG_AW-`EAG_D8){s8}}, v[`EAG_D8-1:0]};
         eag_pkg::EAG_DLEN_12:
            eag_ext = {{(`EAG_AW-`EAG_D12){s12}}, v[`EAG_D12-1:0]};
         eag_pkg::EAG_DLEN_16:
            eag_ext = {{(`EAG_AW-`EAG_D16){s16}}, v[`EAG_D16-1:0]};
         default:
            eag_ext = v;
      endcase
   endfunction

   // ----------------------------------------------------------
   // Operand decode
   // ----------------------------------------------------------
   wire is_cmp  = (repr_i == eag_pkg::EAG_COMPACT);
   wire is_seg  = (repr_i == eag_pkg::EAG_SEGMENTED);
   wire is_calc = (opmode_i == eag_pkg::EAG_CALC_MODE);
   wire is_ind  = (opmode_i == eag_pkg::EAG_INDIRECT_REGISTER_MODE);
   wire is_decrement_branch_nonzero = (opclass_i == eag_pkg::EAG_DECREMENT_BRANCH_NONZERO);
   wire do_sub  = is_decrement_branch_nonzero
                | (opclass_i == eag_pkg::EAG_CALL_RELATIVE);

   // Base source for calculation and port addresses
   wire [`EAG_AW-1:0] base_sel =
      (base_src_i == eag_pkg::EAG_BASE_PC)    ? pc_i :
      (base_src_i == eag_pkg::EAG_BASE_INSTR) ? instr_addr_i :
      base_val_i;
   wire [`EAG_CW-1:0] base16 = base_sel[`EAG_CW-1:0];

   // Extended terms, absent ones are zero
   wire [`EAG_AW-1:0] disp_x =
      eag_ext(disp_i, disp_len_i, is_decrement_branch_nonzero);
   wire [`EAG_AW-1:0] disp_t = use_disp_i ? disp_x : `EAG_ZERO32;
   wire [`EAG_AW-1:0] idx_w  =
      eag_ext(index_val_i, eag_pkg::EAG_DLEN_16, 1'b0);
   wire [`EAG_AW-1:0] idx_t  =
      !use_index_i ? `EAG_ZERO32 :
      index_long_i ? index_val_i : idx_w;

   // ----------------------------------------------------------
   // Address arithmetic
   // ----------------------------------------------------------
   // Compact: one term only, index takes precedence
   wire [`EAG_CW-1:0] c_term =
      use_index_i ? index_val_i[`EAG_CW-1:0] :
      disp_t[`EAG_CW-1:0];
   wire c_sub = do_sub & ~use_index_i & use_disp_i;
   wire [`EAG_CW-1:0] c_ea =
      c_sub ? base16 - c_term : base16 + c_term;

   // Full-width sum, carry dropped
   wire [`EAG_AW-1:0] l_add = base_sel + idx_t;
   wire [`EAG_AW-1:0] l_ea  =
      do_sub ? l_add - disp_t : l_add + disp_t;

   // Segmented: only the offset field takes the sum
   wire seg_large = base_sel[`EAG_SEG_BIT];
   wire [`EAG_AW-1:0] s_ea = seg_large ?
      {base_sel[`EAG_AW-1:`EAG_LS_OFF], l_ea[`EAG_LS_OFF-1:0]} :
      {base_sel[`EAG_AW-1:`EAG_SS_OFF],
       l_ea[`EAG_SS_OFF-1:0]};

   wire [`EAG_AW-1:0] calc_ea =
      is_cmp ? {`EAG_ZERO16, c_ea} :
      is_seg ? s_ea : l_ea;

   wire [`EAG_AW-1:0] ind_ea =
      is_cmp ? {`EAG_ZERO16, base_val_i[`EAG_CW-1:0]} :
      base_val_i;
   wire [`EAG_AW-1:0] imm_ea =
      is_cmp ? {`EAG_ZERO16, pc_i[`EAG_CW-1:0]} : pc_i;
   wire [`EAG_AW-1:0] io_ea = {`EAG_ZERO16, base16};

   wire [`EAG_AW-1:0] ea_d =
      (opmode_i == eag_pkg::EAG_IMMEDIATE_MODE) ? imm_ea :
      is_ind  ? ind_ea :
      is_calc ? calc_ea :
      (opmode_i == eag_pkg::EAG_IO_MODE) ? io_ea :
      `EAG_ZERO32;

   // ----------------------------------------------------------
   // Target space and faults
   // ----------------------------------------------------------
   wire eag_pkg::eag_space_e space_d =
      (opmode_i == eag_pkg::EAG_IMMEDIATE_MODE) ?
         eag_pkg::EAG_SPACE_INSTR :
      is_ind ? (io_op_i ? eag_pkg::EAG_SPACE_IO
                        : eag_pkg::EAG_SPACE_DATA) :
      is_calc ? ((base_src_i == eag_pkg::EAG_BASE_PC) ?
                 eag_pkg::EAG_SPACE_INSTR :
                 eag_pkg::EAG_SPACE_DATA) :
      (opmode_i == eag_pkg::EAG_IO_MODE) ?
         eag_pkg::EAG_SPACE_IO :
      eag_pkg::EAG_SPACE_NONE;

   wire base_is_reg = is_ind
      | (is_calc & (base_src_i == eag_pkg::EAG_BASE_REG));
   wire zero_fault =
      (base_is_reg & (base_reg_i == `EAG_REG_ZERO))
    | (is_calc & use_index_i &
       (index_reg_i == `EAG_REG_ZERO));
   wire both_fault =
      is_calc & is_cmp & use_index_i & use_disp_i;
   wire xlate_d = mmu_en_i
      & (space_d != eag_pkg::EAG_SPACE_NONE);
   wire reg_d = (opmode_i == eag_pkg::EAG_REGISTER_MODE);

   // ----------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------
   logic                  valid_q;
   logic [`EAG_AW-1:0]    ea_q;
   eag_pkg::eag_space_e   space_q;
   logic                  xlate_q;
   logic                  fault_q;
   logic                  reg_q;
   logic [`EAG_RW-1:0]    rnum_q;
   eag_pkg::eag_rsize_e   rsize_q;

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= req_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ea_q    <= `EAG_ZERO32;
         space_q <= eag_pkg::EAG_SPACE_NONE;
         xlate_q <= 1'b0;
         fault_q <= 1'b0;
         reg_q   <= 1'b0;
         rnum_q  <= `EAG_REG_ZERO;
         rsize_q <= eag_pkg::EAG_BYTE;
      end else if (req_i) begin
         ea_q    <= ea_d;
         space_q <= space_d;
         xlate_q <= xlate_d;
         fault_q <= zero_fault | both_fault;
         reg_q   <= reg_d;
         rnum_q  <= base_reg_i;
         rsize_q <= reg_size_i;
      end
   end

   assign valid_o     = valid_q;
   assign ea_o        = ea_q;
   assign space_o     = space_q;
   assign translate_o = xlate_q;
   assign fault_o     = fault_q;
   assign reg_op_o    = reg_q;
   assign reg_num_o   = rnum_q;
   assign reg_size_o  = rsize_q;

   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   wire [`EAG_AW-1:0] chk_sx = {{(`EAG_AW-`EAG_D8){disp_i[`EAG_D8-1]}},
                                disp_i[`EAG_D8-1:0]};
   wire [`EAG_AW-1:0] chk_ix = {{(`EAG_AW-`EAG_CW){index_val_i[`EAG_CW-1]}},
                                index_val_i[`EAG_CW-1:0]};
   wire lin_rq = req_i & is_calc & (repr_i == eag_pkg::EAG_LINEAR);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_sync_n);

   sequence s_lin_d8;
      lin_rq && use_disp_i && !use_index_i
         && disp_len_i == eag_pkg::EAG_DLEN_8;
   endsequence

   sequence s_seg_calc;
      req_i && is_calc && is_seg;
   endsequence

   a_decrement_branch_nonzero_zero_sub: assert property (
      s_lin_d8 and is_decrement_branch_nonzero |=> ea_q == $past(base_sel)
         - ($past(disp_i) & `EAG_LO8))
      else $error("decrement-branch displacement wrong");

   a_disp_sign_add: assert property (
      s_lin_d8 and opclass_i == eag_pkg::EAG_NORMAL
         |=> ea_q == $past(base_sel) + $past(chk_sx))
      else $error("sign-extended displacement wrong");

   a_compact_excl: assert property (
      req_i && both_fault |=> valid_q && fault_q)
      else $error("index with displacement not flagged");

   a_compact_wrap: assert property (
      req_i && is_calc && is_cmp |=> ea_q[`EAG_AW-1:`EAG_CW]
         == `EAG_ZERO16)
      else $error("compact address exceeds 16 bits");

   a_reg_zero: assert property (
      req_i && base_is_reg && base_reg_i == `EAG_REG_ZERO
         |=> fault_q)
      else $error("register zero base not flagged");

   a_index_sext: assert property (
      lin_rq && use_index_i && !index_long_i && !use_disp_i
         |=> ea_q == $past(base_sel) + $past(chk_ix))
      else $error("word index not sign-extended");

   a_seg_keep: assert property (
      s_seg_calc and seg_large |=> ea_q[`EAG_AW-1:`EAG_LS_OFF]
         == $past(base_sel[`EAG_AW-1:`EAG_LS_OFF]))
      else $error("large segment number changed");

   a_seg_small: assert property (
      s_seg_calc and !seg_large |=> (ea_q & ~`EAG_LO16)
         == ($past(base_sel) & ~`EAG_LO16))
      else $error("small segment number changed");

   a_imm_space: assert property (
      req_i && opmode_i == eag_pkg::EAG_IMMEDIATE_MODE && !is_cmp
         |=> space_q == eag_pkg::EAG_SPACE_INSTR
             && ea_q == $past(pc_i))
      else $error("immediate operand space wrong");

   a_ind_space: assert property (
      req_i && is_ind && io_op_i && !is_cmp
         |=> space_q == eag_pkg::EAG_SPACE_IO
             && ea_q == $past(base_val_i))
      else $error("indirect I/O access wrong");

   a_reg_sel: assert property (
      req_i && reg_d |=> reg_q && rsize_q == $past(reg_size_i)
         && space_q == eag_pkg::EAG_SPACE_NONE)
      else $error("register operand select wrong");

   a_translate: assert property (
      req_i |=> xlate_q == ($past(mmu_en_i)
         && space_q != eag_pkg::EAG_SPACE_NONE))
      else $error("translate flag wrong");

   a_io_direct: assert property (
      req_i && opmode_i == eag_pkg::EAG_IO_MODE
         |=> ea_q == ($past(base_sel) & `EAG_LO16))
      else $error("I/O port address altered");

   a_valid_seq: assert property (
      req_i ##1 !req_i |-> valid_q ##1 !valid_q)
      else $error("valid not one cycle per request");

endmodule // eag_top
